// [hw/tcd_map.svh]
`ifndef TCD_MAP_SVH
`define TCD_MAP_SVH
// register lengths of the access port
`define TCD_IR_W 6
`define TCD_CFG_W 112
`define TCD_QCFG_W 40
`define TCD_SIG_W 16
`define TCD_ID_W 32
// instruction codes
`define TCD_I_EXTEST 6'h00
`define TCD_I_SEL_FULL 6'h01
`define TCD_I_SEL_QUICK 6'h02
`define TCD_I_SEL_SIG 6'h03
`define TCD_I_LATCH 6'h05
`define TCD_I_READ_CFG 6'h06
`define TCD_I_READ_SIG 6'h0a
`define TCD_I_PROG_SIG 6'h0b
`define TCD_I_PROG_CFG 6'h0c
`define TCD_I_IDCODE 6'h0d
`define TCD_I_PROG_FUSE 6'h11
`define TCD_I_PWR_DN 6'h12
`define TCD_I_PWR_UP 6'h13
`define TCD_I_RELOAD 6'h16
`define TCD_I_ERASE_CFG 6'h17
`define TCD_I_ERASE_SIG 6'h1b
`define TCD_I_CAL 6'h1c
`define TCD_I_BULK 6'h1d
`define TCD_I_SAMPLE 6'h1e
`define TCD_I_BYPASS 6'h3f
// apb byte addresses
`define TCD_A_STATUS 8'h00
`define TCD_A_CTRL 8'h04
`define TCD_A_IR 8'h08
`define TCD_A_SIG 8'h0c
// status fields
`define TCD_ST_PWR_DN 0
`define TCD_ST_CAL 1
`define TCD_ST_NV_BUSY 2
`define TCD_ST_FUSE 3
`define TCD_ST_QUICK 4
`define TCD_ST_PEND 5
// control fields and reset value
`define TCD_CT_LINK_EN 0
`define TCD_CTRL_RST 32'h0000_0001
// timing, times in microseconds
`define TCD_CLK_MHZ 50
`define TCD_SWITCH_TIME_US 1
`define TCD_NV_TIME_US 10000
`define TCD_CAL_TIME_US 20000
`endif

// [hw/tcd_pkg.sv]
package tcd_pkg;
  // access-port controller states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR,
    TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR,
    TAP_EX2_IR, TAP_UPD_IR
  } tcd_tap_e;
  // decoded operations
  typedef enum logic [4:0] {
    OP_BYPASS, OP_IDCODE, OP_SEL_FULL, OP_SEL_QUICK, OP_SEL_SIG, OP_LATCH, OP_READ_CFG,
    OP_READ_SIG, OP_PROG_SIG, OP_PROG_CFG, OP_PROG_FUSE, OP_PWR_DN, OP_PWR_UP, OP_RELOAD,
    OP_ERASE_CFG, OP_ERASE_SIG, OP_CAL, OP_BULK
  } tcd_op_e;
  // synchronised link pins
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } tcd_pins_s;
endpackage : tcd_pkg

// [hw/tcd_tap_decoder.sv]
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tcd_map.svh"
module tcd_tap_decoder #(
  parameter int unsigned CFG_W = `TCD_CFG_W,
  parameter int unsigned QCFG_W = `TCD_QCFG_W,
  parameter int unsigned SIG_W = `TCD_SIG_W,
  parameter logic [31:0] ID_CODE = 32'h0000_0001, // arbitrary value
  parameter int unsigned NV_CYCLES = `TCD_NV_TIME_US * `TCD_CLK_MHZ,
  parameter int unsigned CAL_CYCLES = `TCD_CAL_TIME_US * `TCD_CLK_MHZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  output logic [CFG_W-1:0] control_mem,
  output logic amp_zero,
  output logic analog_off,
  output logic outputs_hiz
);
  localparam int unsigned IR_W = `TCD_IR_W;
  // switching must finish inside this many cycles
  localparam int unsigned SWITCH_CYC = `TCD_SWITCH_TIME_US * `TCD_CLK_MHZ;

  // link pin synchroniser, stage one feeds stage two only
  tcd_pkg::tcd_pins_s pin_s1_q, pin_s2_q;
  logic tck_s3_q; // previous sampled clock level for edge finding
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      tck_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= '{tck: tck, tms: tms, tdi: tdi};
      pin_s2_q <= pin_s1_q;
      tck_s3_q <= pin_s2_q.tck;
    end
  end
  // edges seen at pclk rate; link clock must be well below pclk/4
  wire logic tck_rise = pin_s2_q.tck & ~tck_s3_q;
  wire logic tck_fall = ~pin_s2_q.tck & tck_s3_q;

  // code to operation; undefined codes fall to bypass
  function automatic tcd_pkg::tcd_op_e decode(input logic [IR_W-1:0] c);
    tcd_pkg::tcd_op_e o;
    o = tcd_pkg::OP_BYPASS;
    if (!c[IR_W-1]) begin
      case (c)
        `TCD_I_SEL_FULL: o = tcd_pkg::OP_SEL_FULL;
        `TCD_I_SEL_QUICK: o = tcd_pkg::OP_SEL_QUICK;
        `TCD_I_SEL_SIG: o = tcd_pkg::OP_SEL_SIG;
        `TCD_I_LATCH: o = tcd_pkg::OP_LATCH;
        `TCD_I_READ_CFG: o = tcd_pkg::OP_READ_CFG;
        `TCD_I_READ_SIG: o = tcd_pkg::OP_READ_SIG;
        `TCD_I_PROG_SIG: o = tcd_pkg::OP_PROG_SIG;
        `TCD_I_PROG_CFG: o = tcd_pkg::OP_PROG_CFG;
        `TCD_I_IDCODE: o = tcd_pkg::OP_IDCODE;
        `TCD_I_PROG_FUSE: o = tcd_pkg::OP_PROG_FUSE;
        `TCD_I_PWR_DN: o = tcd_pkg::OP_PWR_DN;
        `TCD_I_PWR_UP: o = tcd_pkg::OP_PWR_UP;
        `TCD_I_RELOAD: o = tcd_pkg::OP_RELOAD;
        `TCD_I_ERASE_CFG: o = tcd_pkg::OP_ERASE_CFG;
        `TCD_I_ERASE_SIG: o = tcd_pkg::OP_ERASE_SIG;
        `TCD_I_CAL: o = tcd_pkg::OP_CAL;
        `TCD_I_BULK: o = tcd_pkg::OP_BULK;
        default: o = tcd_pkg::OP_BYPASS;
      endcase
    end
    return o;
  endfunction : decode

  // controller stepping on tms
  function automatic tcd_pkg::tcd_tap_e tap_step(input tcd_pkg::tcd_tap_e s, input logic m);
    tcd_pkg::tcd_tap_e n;
    n = s;
    case (s)
      tcd_pkg::TAP_RESET: n = m ? tcd_pkg::TAP_RESET : tcd_pkg::TAP_IDLE;
      tcd_pkg::TAP_IDLE: n = m ? tcd_pkg::TAP_SEL_DR : tcd_pkg::TAP_IDLE;
      tcd_pkg::TAP_SEL_DR: n = m ? tcd_pkg::TAP_SEL_IR : tcd_pkg::TAP_CAP_DR;
      tcd_pkg::TAP_CAP_DR: n = m ? tcd_pkg::TAP_EX1_DR : tcd_pkg::TAP_SH_DR;
      tcd_pkg::TAP_SH_DR: n = m ? tcd_pkg::TAP_EX1_DR : tcd_pkg::TAP_SH_DR;
      tcd_pkg::TAP_EX1_DR: n = m ? tcd_pkg::TAP_UPD_DR : tcd_pkg::TAP_PA_DR;
      tcd_pkg::TAP_PA_DR: n = m ? tcd_pkg::TAP_EX2_DR : tcd_pkg::TAP_PA_DR;
      tcd_pkg::TAP_EX2_DR: n = m ? tcd_pkg::TAP_UPD_DR : tcd_pkg::TAP_SH_DR;
      tcd_pkg::TAP_UPD_DR: n = m ? tcd_pkg::TAP_SEL_DR : tcd_pkg::TAP_IDLE;
      tcd_pkg::TAP_SEL_IR: n = m ? tcd_pkg::TAP_RESET : tcd_pkg::TAP_CAP_IR;
      tcd_pkg::TAP_CAP_IR: n = m ? tcd_pkg::TAP_EX1_IR : tcd_pkg::TAP_SH_IR;
      tcd_pkg::TAP_SH_IR: n = m ? tcd_pkg::TAP_EX1_IR : tcd_pkg::TAP_SH_IR;
      tcd_pkg::TAP_EX1_IR: n = m ? tcd_pkg::TAP_UPD_IR : tcd_pkg::TAP_PA_IR;
      tcd_pkg::TAP_PA_IR: n = m ? tcd_pkg::TAP_EX2_IR : tcd_pkg::TAP_PA_IR;
      tcd_pkg::TAP_EX2_IR: n = m ? tcd_pkg::TAP_UPD_IR : tcd_pkg::TAP_SH_IR;
      tcd_pkg::TAP_UPD_IR: n = m ? tcd_pkg::TAP_SEL_DR : tcd_pkg::TAP_IDLE;
      default: n = tcd_pkg::TAP_RESET;
    endcase
    return n;
  endfunction : tap_step

  // port, shift and nonvolatile state
  tcd_pkg::tcd_tap_e tap_q, tap_d; // controller state
  logic [IR_W-1:0] ir_sr_q, ir_sr_d; // instruction shift stage
  logic [IR_W-1:0] ir_act_q, ir_act_d; // active instruction code
  logic byp_q, byp_d; // single bypass stage
  logic [`TCD_ID_W-1:0] id_sr_q, id_sr_d; // identification shifter
  logic [CFG_W-1:0] cfg_sr_q, cfg_sr_d; // full register; quick is its low part
  logic [SIG_W-1:0] sig_sr_q, sig_sr_d; // user signature shifter
  logic [CFG_W-1:0] nv_cfg_q, nv_cfg_d; // nonvolatile configuration
  logic [SIG_W-1:0] nv_sig_q, nv_sig_d; // nonvolatile signature
  logic fuse_q, fuse_d; // security fuse bit
  logic [CFG_W-1:0] ctrl_q, ctrl_d; // control memory
  logic quick_q, quick_d; // quick register was the last selected
  logic pend_q, pend_d; // deferred instruction waiting for idle
  logic pd_q, pd_d; // powered down
  logic [31:0] nv_cnt_q, nv_cnt_d; // nonvolatile write time left
  logic [31:0] cal_cnt_q, cal_cnt_d; // calibration time left
  logic tdo_q, tdo_d;
  logic oe_q, oe_d;
  logic link_en; // software gate on the port
  logic rti_go; // this cycle enters run-test/idle
  tcd_pkg::tcd_op_e op;

  always_comb op = decode(ir_act_q);

  // shifter selected for data scans
  function automatic logic dr_bit(input tcd_pkg::tcd_op_e o, input logic b, input logic i,
                                  input logic c, input logic s, input logic f);
    logic r;
    r = b;
    case (o)
      tcd_pkg::OP_IDCODE: r = i;
      tcd_pkg::OP_SEL_FULL, tcd_pkg::OP_SEL_QUICK: r = c & ~f;
      tcd_pkg::OP_SEL_SIG: r = s;
      default: r = b;
    endcase
    return r;
  endfunction : dr_bit

  // next values of the port and storage
  always_comb begin
    tap_d = tap_q;
    ir_sr_d = ir_sr_q;
    ir_act_d = ir_act_q;
    byp_d = byp_q;
    id_sr_d = id_sr_q;
    cfg_sr_d = cfg_sr_q;
    sig_sr_d = sig_sr_q;
    nv_cfg_d = nv_cfg_q;
    nv_sig_d = nv_sig_q;
    fuse_d = fuse_q;
    ctrl_d = ctrl_q;
    quick_d = quick_q;
    pend_d = pend_q;
    pd_d = pd_q;
    tdo_d = tdo_q;
    oe_d = oe_q;
    nv_cnt_d = (nv_cnt_q != 32'h0) ? nv_cnt_q - 32'h1 : 32'h0;
    // counts down on pclk alone, so the link may stop at once
    cal_cnt_d = (cal_cnt_q != 32'h0) ? cal_cnt_q - 32'h1 : 32'h0;
    if (!link_en) begin
      tap_d = tcd_pkg::TAP_RESET;
    end else if (tck_rise) begin
      tap_d = tap_step(tap_q, pin_s2_q.tms);
    end
    rti_go = tck_rise && link_en && tap_q != tcd_pkg::TAP_IDLE && tap_d == tcd_pkg::TAP_IDLE;
    // capture and shift on the rising link edge
    if (tck_rise && link_en) begin
      case (tap_q)
        tcd_pkg::TAP_CAP_IR: ir_sr_d = `TCD_I_IDCODE;
        tcd_pkg::TAP_SH_IR: ir_sr_d = {pin_s2_q.tdi, ir_sr_q[IR_W-1:1]};
        tcd_pkg::TAP_CAP_DR: begin
          byp_d = 1'b0;
          if (op == tcd_pkg::OP_IDCODE) begin
            id_sr_d = ID_CODE;
          end
        end
        tcd_pkg::TAP_SH_DR: begin
          case (op)
            tcd_pkg::OP_IDCODE: id_sr_d = {pin_s2_q.tdi, id_sr_q[`TCD_ID_W-1:1]};
            tcd_pkg::OP_SEL_FULL: cfg_sr_d = {pin_s2_q.tdi, cfg_sr_q[CFG_W-1:1]};
            tcd_pkg::OP_SEL_QUICK: begin
              cfg_sr_d[QCFG_W-1:0] = {pin_s2_q.tdi, cfg_sr_q[QCFG_W-1:1]};
            end
            tcd_pkg::OP_SEL_SIG: sig_sr_d = {pin_s2_q.tdi, sig_sr_q[SIG_W-1:1]};
            default: byp_d = pin_s2_q.tdi;
          endcase
        end
        default: begin
        end
      endcase
    end
    // serial output moves on the falling link edge
    if (tck_fall) begin
      oe_d = (tap_q == tcd_pkg::TAP_SH_DR) || (tap_q == tcd_pkg::TAP_SH_IR);
      if (tap_q == tcd_pkg::TAP_SH_IR) begin
        tdo_d = ir_sr_q[0];
      end else if (tap_q == tcd_pkg::TAP_SH_DR) begin
        tdo_d = dr_bit(op, byp_q, id_sr_q[0], cfg_sr_q[0], sig_sr_q[0], fuse_q);
      end
    end
    // immediate group takes effect in update-ir
    if (tck_fall && tap_q == tcd_pkg::TAP_UPD_IR) begin
      ir_act_d = ir_sr_q;
      case (decode(ir_sr_q))
        tcd_pkg::OP_SEL_FULL: quick_d = 1'b0;
        tcd_pkg::OP_SEL_QUICK: quick_d = 1'b1;
        tcd_pkg::OP_READ_CFG: cfg_sr_d = nv_cfg_q;
        tcd_pkg::OP_READ_SIG: sig_sr_d = nv_sig_q;
        default: begin
        end
      endcase
      // deferred group waits for run-test/idle
      case (decode(ir_sr_q))
        tcd_pkg::OP_PROG_CFG, tcd_pkg::OP_PROG_SIG, tcd_pkg::OP_PROG_FUSE, tcd_pkg::OP_LATCH,
        tcd_pkg::OP_ERASE_CFG, tcd_pkg::OP_ERASE_SIG, tcd_pkg::OP_BULK, tcd_pkg::OP_PWR_DN,
        tcd_pkg::OP_PWR_UP, tcd_pkg::OP_RELOAD, tcd_pkg::OP_CAL: pend_d = 1'b1;
        default: pend_d = 1'b0;
      endcase
    end
    // deferred group runs once on idle entry
    if (rti_go && pend_q) begin
      pend_d = 1'b0;
      case (op)
        tcd_pkg::OP_PROG_CFG: begin
          // writes only add ones; a busy store ignores the request
          if (nv_cnt_q == 32'h0) begin
            nv_cfg_d = nv_cfg_q | cfg_sr_q;
            nv_cnt_d = NV_CYCLES;
          end
        end
        tcd_pkg::OP_PROG_SIG: begin
          if (nv_cnt_q == 32'h0) begin
            nv_sig_d = nv_sig_q | sig_sr_q;
            nv_cnt_d = NV_CYCLES;
          end
        end
        tcd_pkg::OP_PROG_FUSE: begin
          if (nv_cnt_q == 32'h0) begin
            fuse_d = 1'b1;
            nv_cnt_d = NV_CYCLES;
          end
        end
        tcd_pkg::OP_ERASE_CFG: begin
          if (nv_cnt_q == 32'h0) begin
            nv_cfg_d = '0;
            nv_cnt_d = NV_CYCLES;
          end
        end
        tcd_pkg::OP_ERASE_SIG: begin
          if (nv_cnt_q == 32'h0) begin
            nv_sig_d = '0;
            nv_cnt_d = NV_CYCLES;
          end
        end
        tcd_pkg::OP_BULK: begin
          if (nv_cnt_q == 32'h0) begin
            nv_cfg_d = '0;
            nv_sig_d = '0;
            fuse_d = 1'b0;
            nv_cnt_d = NV_CYCLES;
          end
        end
        tcd_pkg::OP_LATCH: begin
          if (quick_q) begin
            ctrl_d[QCFG_W-1:0] = cfg_sr_q[QCFG_W-1:0];
          end else begin
            ctrl_d = cfg_sr_q;
          end
        end
        tcd_pkg::OP_RELOAD: ctrl_d = nv_cfg_q;
        tcd_pkg::OP_PWR_DN: pd_d = 1'b1;
        tcd_pkg::OP_PWR_UP: pd_d = 1'b0;
        tcd_pkg::OP_CAL: cal_cnt_d = CAL_CYCLES;
        default: begin
        end
      endcase
    end
    // test-logic-reset selects identification and drops pending work
    if (tap_q == tcd_pkg::TAP_RESET) begin
      ir_act_d = `TCD_I_IDCODE;
      pend_d = 1'b0;
      oe_d = 1'b0;
    end
  end

  // port and storage registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tap_q <= tcd_pkg::TAP_RESET;
      ir_sr_q <= `TCD_I_IDCODE;
      ir_act_q <= `TCD_I_IDCODE;
      byp_q <= 1'b0;
      id_sr_q <= '0;
      cfg_sr_q <= '0;
      sig_sr_q <= '0;
      nv_cfg_q <= '0; // factory state
      nv_sig_q <= '0;
      fuse_q <= 1'b0;
      ctrl_q <= '0;
      quick_q <= 1'b0;
      pend_q <= 1'b0;
      pd_q <= 1'b0;
      nv_cnt_q <= 32'h0;
      cal_cnt_q <= 32'h0;
      tdo_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      tap_q <= tap_d;
      ir_sr_q <= ir_sr_d;
      ir_act_q <= ir_act_d;
      byp_q <= byp_d;
      id_sr_q <= id_sr_d;
      cfg_sr_q <= cfg_sr_d;
      sig_sr_q <= sig_sr_d;
      nv_cfg_q <= nv_cfg_d;
      nv_sig_q <= nv_sig_d;
      fuse_q <= fuse_d;
      ctrl_q <= ctrl_d;
      quick_q <= quick_d;
      pend_q <= pend_d;
      pd_q <= pd_d;
      nv_cnt_q <= nv_cnt_d;
      cal_cnt_q <= cal_cnt_d;
      tdo_q <= tdo_d;
      oe_q <= oe_d;
    end
  end

  assign tdo = tdo_q;
  assign tdo_oe = oe_q;
  assign control_mem = ctrl_q;
  // amplifiers held at zero for the whole calibration
  assign amp_zero = cal_cnt_q != 32'h0;
  assign analog_off = pd_q;
  assign outputs_hiz = pd_q;

  // apb slave: zero wait, read data caught in the setup cycle
  logic [31:0] ctrl_reg_q, ctrl_reg_d; // software control word
  logic [31:0] prdata_q, prdata_d;
  logic [31:0] status;
  logic hit;
  always_comb begin
    status = 32'h0;
    status[`TCD_ST_PWR_DN] = pd_q;
    status[`TCD_ST_CAL] = amp_zero;
    status[`TCD_ST_NV_BUSY] = nv_cnt_q != 32'h0;
    status[`TCD_ST_FUSE] = fuse_q;
    status[`TCD_ST_QUICK] = quick_q;
    status[`TCD_ST_PEND] = pend_q;
    hit = (paddr == `TCD_A_STATUS) || (paddr == `TCD_A_CTRL) ||
          (paddr == `TCD_A_IR) || (paddr == `TCD_A_SIG);
    ctrl_reg_d = ctrl_reg_q;
    prdata_d = prdata_q;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        `TCD_A_STATUS: prdata_d = status;
        `TCD_A_CTRL: prdata_d = ctrl_reg_q;
        `TCD_A_IR: prdata_d = {26'h0, ir_act_q};
        `TCD_A_SIG: prdata_d = {{(32 - SIG_W){1'b0}}, nv_sig_q};
        default: prdata_d = 32'h0;
      endcase
    end
    if (psel && penable && pwrite && paddr == `TCD_A_CTRL) begin
      ctrl_reg_d = {31'h0, pwdata[`TCD_CT_LINK_EN]};
    end
  end
  // apb registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg_q <= `TCD_CTRL_RST;
      prdata_q <= 32'h0;
    end else begin
      ctrl_reg_q <= ctrl_reg_d;
      prdata_q <= prdata_d;
    end
  end
  assign link_en = ctrl_reg_q[`TCD_CT_LINK_EN];
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic upd_ir = tck_fall && tap_q == tcd_pkg::TAP_UPD_IR;
  a_msb_bypass: assert property (upd_ir && ir_sr_q[IR_W-1] |=> op == tcd_pkg::OP_BYPASS)
    else $error("leading one did not decode as bypass");
  a_reset_idcode: assert property (tap_q == tcd_pkg::TAP_RESET |=> op == tcd_pkg::OP_IDCODE)
    else $error("identification not selected in reset state");
  a_bypass_out: assert property (tck_fall && tap_q == tcd_pkg::TAP_SH_DR &&
    op == tcd_pkg::OP_BYPASS |=> tdo == $past(byp_q) && tdo_oe)
    else $error("bypass stage not on serial output");
  a_fuse_zeros: assert property (tck_fall && tap_q == tcd_pkg::TAP_SH_DR && fuse_q &&
    (op == tcd_pkg::OP_SEL_FULL || op == tcd_pkg::OP_SEL_QUICK) |=> !tdo)
    else $error("fused configuration leaked on serial output");
  a_prog_idle: assert property (rti_go && pend_q && op == tcd_pkg::OP_PROG_CFG &&
    nv_cnt_q == 32'h0 |=> nv_cnt_q != 32'h0 && nv_cfg_q == ($past(nv_cfg_q) | $past(cfg_sr_q)))
    else $error("configuration program not started on idle entry");
  a_bulk_all: assert property (rti_go && pend_q && op == tcd_pkg::OP_BULK &&
    nv_cnt_q == 32'h0 |=> nv_cfg_q == '0 && nv_sig_q == '0 && !fuse_q)
    else $error("bulk erase left stored bits set");
  a_cal_hold: assert property (rti_go && pend_q && op == tcd_pkg::OP_CAL |=>
    amp_zero [*8])
    else $error("amplifiers released early in calibration");
  a_ctrl_defer: assert property (!(rti_go && pend_q) |=> $stable(ctrl_q))
    else $error("control memory changed outside idle entry");
  a_quick_part: assert property (rti_go && pend_q && op == tcd_pkg::OP_LATCH && quick_q |=>
    $stable(ctrl_q[CFG_W-1:QCFG_W]))
    else $error("quick latch touched upper control memory");
  a_switch_time: assert property (rti_go && pend_q && op == tcd_pkg::OP_RELOAD |->
    ##[1:SWITCH_CYC] ctrl_q == $past(nv_cfg_q))
    else $error("reload did not switch within a microsecond");
  a_pwr_down: assert property (rti_go && pend_q && op == tcd_pkg::OP_PWR_DN |=>
    analog_off && outputs_hiz)
    else $error("power down not applied on idle entry");
endmodule : tcd_tap_decoder
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tcd_map.svh"
module tb_top;
  localparam logic [31:0] ID = 32'h5a3c_0f01; // arbitrary value
  localparam int NV = 20;
  localparam int CAL = 200;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic tck, tms, tdi, tdo, tdo_oe, amp_zero, analog_off, outputs_hiz;
  logic [111:0] control_mem, q, pat;
  logic [5:0] bp [6];
  int miscompares, checks_done;
  tcd_tap_decoder #(.ID_CODE(ID), .NV_CYCLES(NV), .CAL_CYCLES(CAL)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .control_mem(control_mem),
    .amp_zero(amp_zero), .analog_off(analog_off), .outputs_hiz(outputs_hiz));
  tcd_host host (.pclk(pclk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [111:0] e, input logic [111:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // select the signature, load it, run op, then read the stored copy
  task automatic sig_step(input logic [5:0] op, input logic [15:0] v, input logic [31:0] e);
    host.scan(1'b1, 6, 112'(`TCD_I_SEL_SIG), q);
    host.scan(1'b0, 16, 112'(v), q);
    host.scan(1'b1, 6, 112'(op), q);
    repeat (NV + 10) @(posedge pclk);
    apb(1'b0, `TCD_A_SIG, 32'h0);
    chk("stored signature", 112'(e), 112'(rd));
  endtask : sig_step
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  initial begin
    repeat (80000) @(posedge pclk);
    miscompares++;
    $display("[ERR] watchdog expected done seen timeout");
    close_out();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    miscompares = 0;
    checks_done = 0;
    bp = '{`TCD_I_EXTEST, `TCD_I_SAMPLE, `TCD_I_BYPASS, 6'h20, 6'h04, 6'h2d};
    pat = {4{28'h9e37c15}};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    host.walk(8'h00, 1);
    host.scan(1'b0, 32, '0, q);
    chk("id after reset", 112'(ID), 112'(q[31:0]));
    apb(1'b0, `TCD_A_CTRL, 32'h0);
    chk("ctrl reset", 112'(`TCD_CTRL_RST), 112'(rd));
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 112'(1'b1), 112'(er));
    apb(1'b1, `TCD_A_CTRL, 32'h0);
    apb(1'b0, `TCD_A_CTRL, 32'h0);
    chk("ctrl written", 112'h0, 112'(rd));
    apb(1'b1, `TCD_A_CTRL, 32'h1);
    $display("apb test done");
    host.walk(8'h00, 1);
    foreach (bp[i]) begin
      host.scan(1'b1, 6, 112'(bp[i]), q);
      apb(1'b0, `TCD_A_IR, 32'h0);
      chk("active code", 112'(bp[i]), 112'(rd));
      host.scan(1'b0, 8, 112'ha5, q);
      chk("bypass path", 112'h4a, q);
    end
    host.scan(1'b1, 6, 112'(`TCD_I_IDCODE), q);
    host.scan(1'b0, 32, '0, q);
    chk("id path", 112'(ID), 112'(q[31:0]));
    $display("path test done");
    host.scan(1'b1, 6, 112'(`TCD_I_SEL_SIG), q);
    host.scan(1'b0, 16, 112'h3c5a, q);
    host.scan(1'b0, 16, 112'h0f0f, q);
    chk("sig loop", 112'h3c5a, q);
    sig_step(`TCD_I_PROG_SIG, 16'h0f0f, 32'h0f0f);
    sig_step(`TCD_I_PROG_SIG, 16'h3c5a, 32'h3f5f);
    host.scan(1'b1, 6, 112'(`TCD_I_READ_SIG), q);
    host.scan(1'b1, 6, 112'(`TCD_I_SEL_SIG), q);
    host.scan(1'b0, 16, '0, q);
    chk("sig read", 112'h3f5f, q);
    sig_step(`TCD_I_ERASE_SIG, 16'h1234, 32'h0);
    sig_step(`TCD_I_PROG_SIG, 16'h00ff, 32'h00ff);
    $display("signature test done");
    host.scan(1'b1, 6, 112'(`TCD_I_SEL_FULL), q);
    host.scan(1'b0, 112, pat, q);
    host.scan(1'b1, 6, 112'(`TCD_I_LATCH), q);
    repeat (50) @(posedge pclk);
    chk("latch full", pat, control_mem);
    host.scan(1'b1, 6, 112'(`TCD_I_SEL_QUICK), q);
    host.scan(1'b0, 40, '0, q);
    host.scan(1'b1, 6, 112'(`TCD_I_LATCH), q);
    repeat (50) @(posedge pclk);
    chk("latch quick", {pat[111:40], 40'h0}, control_mem);
    host.scan(1'b1, 6, 112'(`TCD_I_RELOAD), q);
    repeat (50) @(posedge pclk);
    chk("reload", '0, control_mem);
    host.scan(1'b1, 6, 112'(`TCD_I_PROG_FUSE), q);
    repeat (NV + 10) @(posedge pclk);
    apb(1'b0, `TCD_A_STATUS, 32'h0);
    chk("fuse set", 112'h1, 112'(rd[`TCD_ST_FUSE]));
    host.scan(1'b1, 6, 112'(`TCD_I_SEL_FULL), q);
    host.scan(1'b0, 112, pat, q);
    host.scan(1'b0, 112, pat, q);
    chk("fused readout", '0, q);
    host.scan(1'b1, 6, 112'(`TCD_I_BULK), q);
    repeat (NV + 10) @(posedge pclk);
    apb(1'b0, `TCD_A_STATUS, 32'h0);
    chk("fuse cleared", '0, 112'(rd[`TCD_ST_FUSE]));
    apb(1'b0, `TCD_A_SIG, 32'h0);
    chk("bulk sig", '0, 112'(rd));
    // configuration store: program, reload, read back, then erase
    host.scan(1'b1, 6, 112'(`TCD_I_SEL_FULL), q);
    host.scan(1'b0, 112, pat, q);
    host.scan(1'b1, 6, 112'(`TCD_I_PROG_CFG), q);
    repeat (NV + 10) @(posedge pclk);
    host.scan(1'b1, 6, 112'(`TCD_I_RELOAD), q);
    repeat (50) @(posedge pclk);
    chk("reload stored", pat, control_mem);
    host.scan(1'b1, 6, 112'(`TCD_I_SEL_FULL), q);
    host.scan(1'b0, 112, '0, q);
    chk("cfg loop", pat, q);
    host.scan(1'b1, 6, 112'(`TCD_I_READ_CFG), q);
    host.scan(1'b1, 6, 112'(`TCD_I_SEL_FULL), q);
    host.scan(1'b0, 112, '0, q);
    chk("cfg read", pat, q);
    host.scan(1'b1, 6, 112'(`TCD_I_ERASE_CFG), q);
    repeat (NV + 10) @(posedge pclk);
    host.scan(1'b1, 6, 112'(`TCD_I_RELOAD), q);
    repeat (50) @(posedge pclk);
    chk("cfg erased", '0, control_mem);
    $display("memory test done");
    host.scan(1'b1, 6, 112'(`TCD_I_PWR_DN), q);
    repeat (50) @(posedge pclk);
    chk("powered down", 112'h3, 112'({analog_off, outputs_hiz}));
    host.scan(1'b1, 6, 112'(`TCD_I_PWR_UP), q);
    repeat (50) @(posedge pclk);
    chk("powered up", '0, 112'({analog_off, outputs_hiz}));
    host.scan(1'b1, 6, 112'(`TCD_I_CAL), q);
    repeat (5) @(posedge pclk);
    chk("amp held", 112'h1, 112'(amp_zero));
    host.walk(8'h1f, 5);
    chk("amp held on", 112'h1, 112'(amp_zero));
    repeat (CAL) @(posedge pclk);
    chk("amp free", '0, 112'(amp_zero));
    chk("oe parked", '0, 112'(tdo_oe));
    $display("analog test done");
    close_out();
  end
endmodule : tb_top
`default_nettype wire

// [tb/tcd_host.sv]
`timescale 1ns/1ps
`default_nettype none
// serial test host: test clock runs only inside frames, 8 pclk a period
module tcd_host (
  input wire logic pclk,
  input wire logic tdo,
  output logic tck,
  output logic tms,
  output logic tdi
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // levels change with the fall, serial out is taken just before next fall
  task automatic tick(input logic m, input logic d, output logic o);
    @(posedge pclk);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge pclk);
    tck <= 1'b1;
    repeat (3) @(posedge pclk);
    o = tdo;
  endtask : tick
  // mode-select path, first step in bit 0
  task automatic walk(input logic [7:0] p, input int n);
    logic o;
    for (int i = 0; i < n; i++) tick(p[i], 1'b0, o);
  endtask : walk
  // one scan from idle back to idle, lsb first
  task automatic scan(input logic ir, input int n, input logic [111:0] din,
                      output logic [111:0] dout);
    logic o;
    dout = '0;
    walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
    end
    walk(8'h01, 2);
    // idle data line must not look like a held value
    tdi <= ~tdi;
  endtask : scan
endmodule : tcd_host
`default_nettype wire
